/* verilog/phase_pwm_pkg.sv */
package phase_pwm_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int DT_W = 9;
    localparam int REP_W = 8;
    localparam int NUM_TIMERS = 3;
    localparam logic [15:0] CNT_RESET_VAL = 16'h0000;
    localparam logic [15:0] RELOAD_MAX = 16'hFFFF;
    localparam logic [8:0] DT_RESET_VAL = 9'h000;
    localparam logic [7:0] REP_RESET_VAL = 8'h00;
    localparam logic [15:0] CMP_RESET_VAL = 16'h0000;
    localparam int LEAD = 0;
    localparam int SECOND = 1;
    localparam int THIRD = 2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] period_reload;
        logic [15:0] duty_compare;
        logic [15:0] phase_shift_compare;
        logic [15:0] sample_compare;
        logic [15:0] second_shift_compare;
    } cmp_set_s;

    typedef struct packed {
        logic       deadtime_on;
        logic       shadow_on;
        logic       update_on_reset;
        logic       update_disable;
        logic [8:0] rise_deadtime_value;
        logic [8:0] fall_deadtime_value;
    } timer_cfg_s;

    typedef enum logic [1:0] {
        DT_OFF  = 2'b00,
        DT_RISE = 2'b01,
        DT_ON   = 2'b11,
        DT_FALL = 2'b10
    } dt_state_e;

endpackage

/* verilog/deadtime_pair.sv */
`timescale 1ns/1ps
`default_nettype none

// Turns one PWM level into a complementary pair with dead-time gaps.
module deadtime_pair
    import phase_pwm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             deadtime_tick,
    input  wire logic             deadtime_on,
    input  wire logic [DT_W-1:0]  rise_deadtime_value,
    input  wire logic [DT_W-1:0]  fall_deadtime_value,
    input  wire logic             level_in,
    output logic                  high_side,
    output logic                  low_side
);
    dt_state_e        state_q;
    dt_state_e        state_d;
    logic [DT_W-1:0]  cnt_q;
    logic [DT_W-1:0]  cnt_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            DT_OFF:
            begin
                if (level_in)
                begin
                    state_d = DT_RISE;
                    cnt_d = rise_deadtime_value;
                end
            end
            DT_RISE:
            begin
                if (!level_in)
                    state_d = DT_OFF;
                else if (cnt_q == '0)
                    state_d = DT_ON;
                else if (deadtime_tick)
                    cnt_d = cnt_q - 1'b1;
            end
            DT_ON:
            begin
                if (!level_in)
                begin
                    state_d = DT_FALL;
                    cnt_d = fall_deadtime_value;
                end
            end
            DT_FALL:
            begin
                if (level_in)
                    state_d = DT_ON;
                else if (cnt_q == '0)
                    state_d = DT_OFF;
                else if (deadtime_tick)
                    cnt_d = cnt_q - 1'b1;
            end
        endcase
        if (!deadtime_on)
        begin
            state_d = level_in ? DT_ON : DT_OFF;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= DT_OFF;
            cnt_q <= DT_RESET_VAL;
            high_side <= 1'b0;
            low_side <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            // Both sides stay low while a gap is running.
            high_side <= (state_d == DT_ON);
            low_side <= deadtime_on ? (state_d == DT_OFF) : 1'b0;
        end
    end

    a_gap_no_overlap : assert property (@(posedge clk) disable iff (!reset_n)
        !(high_side && low_side))
        else $error("complementary outputs overlap");

endmodule

`default_nettype wire

/* verilog/three_phase_interleaved_pwm.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Lead counter free-runs, reloads at period_reload, giving period and reset events.
// - Lead phase_shift_compare match resets the second timer's counter.
// - Lead second_shift_compare match resets the third timer's counter.
// - Lead output sets on period; others set on their phase_shift_compare.
// - Every first_output clears when its counter matches its duty_compare.
// - With deadtime_on, second_output is the dead-timed complement of first_output.
// - Nine-bit rise and fall dead-times counted in deadtime_tick periods.
// - With shadow_on, compare writes land in shadow copies until update.
// - With update_on_reset, shadows load at each timer's own counter reset.
// - With reset_irq_enable, lead counter resets raise timer_irq_line_one.
// - Repetition source fires the interrupt once every repeat_count+1 periods.
// - Lead sample_compare match pulses converter_trigger_out0.
// - Each timer holds its own duty_compare, independent of phase shift.
// - Counting gated by counter_run_bits; outputs gated by output_enable_reg.
// - Set update_disable suppresses that timer's shadow transfer.
module three_phase_interleaved_pwm
(
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    input  wire logic                                   deadtime_tick,
    input  wire phase_pwm_pkg::cmp_set_s [2:0]          cmp_write,
    input  wire logic [2:0]                             cmp_write_en,
    input  wire phase_pwm_pkg::timer_cfg_s [2:0]        timer_cfg,
    input  wire logic [2:0]                             counter_run_bits,
    input  wire logic [5:0]                             output_enable_reg,
    input  wire logic                                   reset_irq_enable,
    input  wire logic                                   repeat_irq_select,
    input  wire logic [phase_pwm_pkg::REP_W-1:0]        repeat_count,
    output logic [2:0]                                  first_output,
    output logic [2:0]                                  second_output,
    output logic                                        timer_irq_line_one,
    output logic                                        converter_trigger_out0,
    output logic [phase_pwm_pkg::CNT_W-1:0]             lead_count
);
    import phase_pwm_pkg::*;

    // ----------------------------------------------------------------
    // Compare registers
    // ----------------------------------------------------------------
    cmp_set_s [2:0]      shadow_q;
    cmp_set_s [2:0]      shadow_d;
    cmp_set_s [2:0]      active_q;
    cmp_set_s [2:0]      active_d;
    logic [CNT_W-1:0]    cnt_q [3];
    logic [CNT_W-1:0]    cnt_d [3];
    logic [2:0]          level_q;
    logic [2:0]          level_d;
    logic [2:0]          cnt_rst;
    logic [2:0]          hi_side;
    logic [2:0]          lo_side;
    logic [REP_W-1:0]    rep_q;
    logic [REP_W-1:0]    rep_d;
    logic                irq_d;
    logic                trig_d;
    logic                lead_phase_hit;
    logic                lead_second_hit;

    function automatic logic hit(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] v);
        hit = (c == v);
    endfunction

    // ----------------------------------------------------------------
    // Counter reset events
    // ----------------------------------------------------------------
    always_comb
    begin
        lead_phase_hit = counter_run_bits[LEAD]
            && hit(cnt_q[LEAD], active_q[LEAD].phase_shift_compare);
        lead_second_hit = counter_run_bits[LEAD]
            && hit(cnt_q[LEAD], active_q[LEAD].second_shift_compare);
        cnt_rst[LEAD] = counter_run_bits[LEAD]
            && hit(cnt_q[LEAD], active_q[LEAD].period_reload);
        // Follower resets come from lead compares, so all three phases stay
        // locked to the one lead period.
        // Own reload still applies; with maximum reload it never comes first.
        cnt_rst[SECOND] = lead_phase_hit
            || (counter_run_bits[SECOND]
            && hit(cnt_q[SECOND], active_q[SECOND].period_reload));
        cnt_rst[THIRD] = lead_second_hit
            || (counter_run_bits[THIRD]
            && hit(cnt_q[THIRD], active_q[THIRD].period_reload));
    end

    // ----------------------------------------------------------------
    // Per-timer counting, shadow and output level
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            shadow_d[i] = cmp_write_en[i] ? cmp_write[i] : shadow_q[i];
            active_d[i] = active_q[i];
            level_d[i] = level_q[i];
            cnt_d[i] = cnt_q[i];
            if (!timer_cfg[i].shadow_on && cmp_write_en[i])
                active_d[i] = cmp_write[i];
            else if (timer_cfg[i].shadow_on && timer_cfg[i].update_on_reset
                && cnt_rst[i] && !timer_cfg[i].update_disable)
                active_d[i] = shadow_q[i];
            if (cnt_rst[i])
                cnt_d[i] = CNT_RESET_VAL;
            else if (counter_run_bits[i])
                cnt_d[i] = cnt_q[i] + 1'b1;
            // Set is decided after clear, so a set and a clear in one cycle
            // leave the output high.
            if (counter_run_bits[i])
            begin
                if (hit(cnt_q[i], active_q[i].duty_compare))
                    level_d[i] = 1'b0;
                if (i == LEAD ? cnt_rst[i]
                    : hit(cnt_q[i], active_q[i].phase_shift_compare))
                    level_d[i] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt and converter trigger
    // ----------------------------------------------------------------
    always_comb
    begin
        // The repetition count is reloaded only when it fires, so a new
        // repeat_count takes effect after the next interrupt.
        rep_d = rep_q;
        irq_d = 1'b0;
        if (cnt_rst[LEAD])
        begin
            if (!repeat_irq_select)
                irq_d = reset_irq_enable;
            else if (rep_q == '0)
            begin
                irq_d = reset_irq_enable;
                rep_d = repeat_count;
            end
            else
                rep_d = rep_q - 1'b1;
        end
        trig_d = counter_run_bits[LEAD]
            && hit(cnt_q[LEAD], active_q[LEAD].sample_compare);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                shadow_q[i] <= '{RELOAD_MAX, CMP_RESET_VAL, CMP_RESET_VAL,
                    CMP_RESET_VAL, CMP_RESET_VAL};
                active_q[i] <= '{RELOAD_MAX, CMP_RESET_VAL, CMP_RESET_VAL,
                    CMP_RESET_VAL, CMP_RESET_VAL};
                cnt_q[i] <= CNT_RESET_VAL;
            end
            level_q <= 3'h0;
            rep_q <= REP_RESET_VAL;
            timer_irq_line_one <= 1'b0;
            converter_trigger_out0 <= 1'b0;
            lead_count <= CNT_RESET_VAL;
            first_output <= 3'h0;
            second_output <= 3'h0;
        end
        else
        begin
            shadow_q <= shadow_d;
            active_q <= active_d;
            for (int i = 0; i < NUM_TIMERS; i++)
                cnt_q[i] <= cnt_d[i];
            level_q <= level_d;
            rep_q <= rep_d;
            timer_irq_line_one <= irq_d;
            converter_trigger_out0 <= trig_d;
            lead_count <= cnt_q[LEAD];
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                first_output[i] <= hi_side[i] && output_enable_reg[2*i];
                second_output[i] <= lo_side[i] && output_enable_reg[2*i+1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Dead-time stages
    // ----------------------------------------------------------------
    // The output register adds one cycle behind each dead-time stage; both
    // pins of a pair share it, so the inserted gap is kept.
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++)
        begin : g_dt
            deadtime_pair u_dt (
                .clk                 (clk),
                .reset_n             (reset_n),
                .deadtime_tick       (deadtime_tick),
                .deadtime_on         (timer_cfg[g].deadtime_on),
                .rise_deadtime_value (timer_cfg[g].rise_deadtime_value),
                .fall_deadtime_value (timer_cfg[g].fall_deadtime_value),
                .level_in            (level_q[g]),
                .high_side           (hi_side[g]),
                .low_side            (lo_side[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_lead_wrap : assert property (@(posedge clk) disable iff (!reset_n)
        cnt_rst[LEAD] |=> cnt_q[LEAD] == CNT_RESET_VAL)
        else $error("lead counter did not reload");
    a_second_phase : assert property (@(posedge clk) disable iff (!reset_n)
        lead_phase_hit |=> cnt_q[SECOND] == CNT_RESET_VAL)
        else $error("second counter not reset by lead");
    a_third_phase : assert property (@(posedge clk) disable iff (!reset_n)
        lead_second_hit |=> cnt_q[THIRD] == CNT_RESET_VAL)
        else $error("third counter not reset by lead");
    a_lead_set : assert property (@(posedge clk) disable iff (!reset_n)
        cnt_rst[LEAD] |=> level_q[LEAD])
        else $error("lead output not set on period");
    a_duty_clear : assert property (@(posedge clk) disable iff (!reset_n)
        counter_run_bits[SECOND] && hit(cnt_q[SECOND], active_q[SECOND].duty_compare)
        && !hit(cnt_q[SECOND], active_q[SECOND].phase_shift_compare)
        |=> !level_q[SECOND])
        else $error("second output not cleared on duty");
    a_shadow_hold : assert property (@(posedge clk) disable iff (!reset_n)
        timer_cfg[LEAD].shadow_on && !cnt_rst[LEAD] |=> $stable(active_q[LEAD]))
        else $error("active compare changed outside update");
    a_update_block : assert property (@(posedge clk) disable iff (!reset_n)
        timer_cfg[THIRD].update_disable && timer_cfg[THIRD].shadow_on
        |=> $stable(active_q[THIRD]))
        else $error("update not suppressed");

    // A converter start is one cycle wide so an edge or level input sees it once.
    sequence s_trig_pulse;
        converter_trigger_out0 ##1 !converter_trigger_out0;
    endsequence

    a_trig_pulse : assert property (@(posedge clk) disable iff (!reset_n)
        trig_d |=> s_trig_pulse)
        else $error("converter trigger not a pulse");
    a_run_hold : assert property (@(posedge clk) disable iff (!reset_n)
        !counter_run_bits[LEAD] |=> $stable(cnt_q[LEAD]))
        else $error("stopped counter moved");
    a_irq_reset : assert property (@(posedge clk) disable iff (!reset_n)
        cnt_rst[LEAD] && reset_irq_enable && !repeat_irq_select |=> timer_irq_line_one)
        else $error("interrupt missing on reset");

    sequence s_rep_due;
        repeat_irq_select && cnt_rst[LEAD] && rep_q == '0;
    endsequence

    a_rep_fire : assert property (@(posedge clk) disable iff (!reset_n)
        s_rep_due |=> timer_irq_line_one == $past(reset_irq_enable))
        else $error("repetition interrupt missing");
    a_rep_skip : assert property (@(posedge clk) disable iff (!reset_n)
        repeat_irq_select && cnt_rst[LEAD] && rep_q != '0 |=> !timer_irq_line_one)
        else $error("repetition interrupt fired early");
    a_irq_cause : assert property (@(posedge clk) disable iff (!reset_n)
        timer_irq_line_one |-> $past(cnt_rst[LEAD]))
        else $error("interrupt without lead counter reset");

    // ----------------------------------------------------------------
    // Per-timer checks
    // ----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < NUM_TIMERS; k++)
        begin : g_chk
            a_high_gate : assert property (@(posedge clk) disable iff (!reset_n)
                !output_enable_reg[2*k] |=> !first_output[k])
                else $error("first output driven while disabled");
            a_low_gate : assert property (@(posedge clk) disable iff (!reset_n)
                !output_enable_reg[2*k+1] |=> !second_output[k])
                else $error("second output driven while disabled");
            // A stopped follower may still be reset by the lead, which keeps the phase.
            a_idle_hold : assert property (@(posedge clk) disable iff (!reset_n)
                !counter_run_bits[k] && !cnt_rst[k] |=> $stable(cnt_q[k]))
                else $error("stopped timer counter moved");
            a_reset_zero : assert property (@(posedge clk) disable iff (!reset_n)
                cnt_rst[k] |=> cnt_q[k] == CNT_RESET_VAL)
                else $error("counter not cleared on its reset");
            a_direct_load : assert property (@(posedge clk) disable iff (!reset_n)
                !timer_cfg[k].shadow_on && cmp_write_en[k]
                |=> active_q[k] == $past(cmp_write[k]))
                else $error("unshadowed write did not reach active compare");
            a_reset_update : assert property (@(posedge clk) disable iff (!reset_n)
                timer_cfg[k].shadow_on && timer_cfg[k].update_on_reset
                && !timer_cfg[k].update_disable && cnt_rst[k]
                |=> active_q[k] == $past(shadow_q[k]))
                else $error("shadow not transferred at counter reset");
            if (k != LEAD)
            begin : g_follow
                a_phase_set : assert property (@(posedge clk) disable iff (!reset_n)
                    counter_run_bits[k] && hit(cnt_q[k], active_q[k].phase_shift_compare)
                    |=> level_q[k])
                    else $error("follower output not set on its phase compare");
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* bench/gate_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Gate drivers of the three legs and the converter start input
// ----------------------------------------------------------------
module gate_drive_model
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] high_gate,
    input  wire logic [2:0] low_gate,
    input  wire logic       conv_start,
    output var  int         n_shoot,
    output var  int         n_conv
);
    // Both switches of one leg on together would short the supply rail.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            n_shoot <= 0;
            n_conv <= 0;
        end
        else
        begin
            if ((high_gate & low_gate) != 3'h0)
                n_shoot <= n_shoot + 1;
            if (conv_start === 1'b1)
                n_conv <= n_conv + 1;
        end
    end
endmodule

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import phase_pwm_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             deadtime_tick = 1'b0;
    cmp_set_s [2:0]   cmp_write = '0;
    logic [2:0]       cmp_write_en = '0;
    timer_cfg_s [2:0] timer_cfg = '0;
    logic [2:0]       counter_run_bits = '0;
    logic [5:0]       output_enable_reg = '0;
    logic             reset_irq_enable = 1'b0;
    logic             repeat_irq_select = 1'b0;
    logic [REP_W-1:0] repeat_count = '0;
    logic [2:0]       first_output;
    logic [2:0]       second_output;
    logic             timer_irq_line_one;
    logic             converter_trigger_out0;
    logic [CNT_W-1:0] lead_count;
    logic [2:0]       f_q = '0;
    logic [2:0]       seen_f = '0;
    logic [2:0]       seen_s = '0;
    logic             s_q = 1'b0;
    logic             trig_chk = 1'b0;
    logic [15:0]      per, d0, d0n, d1, d1n, samp, ps, ss, cnt;
    logic [8:0]       fv;
    int               n_mismatch = 0;
    int               total_checks = 0;
    int               cyc = 0;
    int               irq_t = 0;
    int               irq_prev = 0;
    int               dt_gap = 0;
    int               rise_t[3];
    int               fall_t[3];
    int               n_shoot;
    int               n_conv;

    always #12.5 clk = ~clk;

    three_phase_interleaved_pwm dut (
        .clk(clk), .reset_n(reset_n), .deadtime_tick(deadtime_tick),
        .cmp_write(cmp_write), .cmp_write_en(cmp_write_en), .timer_cfg(timer_cfg),
        .counter_run_bits(counter_run_bits), .output_enable_reg(output_enable_reg),
        .reset_irq_enable(reset_irq_enable), .repeat_irq_select(repeat_irq_select),
        .repeat_count(repeat_count), .first_output(first_output),
        .second_output(second_output), .timer_irq_line_one(timer_irq_line_one),
        .converter_trigger_out0(converter_trigger_out0), .lead_count(lead_count));

    gate_drive_model partner (
        .clk(clk), .reset_n(reset_n), .high_gate(first_output),
        .low_gate(second_output), .conv_start(converter_trigger_out0),
        .n_shoot(n_shoot), .n_conv(n_conv));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t exp %0h got %0h", $time, exp, got);
        end
    endtask

    // Edge times are taken modulo the lead period so their order does not matter.
    function automatic int md(input int a);
        int p;
        p = int'(per) + 1;
        return ((a % p) + p) % p;
    endfunction

    function automatic int width(input int i);
        return md(fall_t[i] - rise_t[i]);
    endfunction

    task automatic waitp(input int n);
        repeat (n * (per + 1)) @(negedge clk);
    endtask

    task automatic load(input int i, input logic [15:0] r, d, p, s, t);
        @(negedge clk);
        cmp_write[i] = '{r, d, p, s, t};
        cmp_write_en[i] = 1'b1;
        @(negedge clk);
        cmp_write_en[i] = 1'b0;
    endtask

    always @(negedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (first_output[i] === 1'b1 && !f_q[i])
                rise_t[i] = cyc;
            if (first_output[i] === 1'b0 && f_q[i])
                fall_t[i] = cyc;
        end
        if (second_output[0] === 1'b1 && !s_q)
            dt_gap = cyc - fall_t[0];
        if (timer_irq_line_one === 1'b1)
        begin
            irq_prev = irq_t;
            irq_t = cyc;
        end
        if (trig_chk)
            check(lead_count == samp, converter_trigger_out0);
        seen_f = seen_f | first_output;
        seen_s = seen_s | second_output;
        f_q = first_output;
        s_q = second_output[0];
        cyc++;
        if (cyc > 15000)
        begin
            n_mismatch++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(95));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        per = 16'(60 + $urandom % 40);
        d0 = 16'(10 + $urandom % 20);
        d1 = 16'(8 + $urandom % 20);
        ps = per / 3;
        ss = 16'(2 * per / 3);
        samp = d0 / 2;
        load(0, per, d0, ps, samp, ss);
        load(1, RELOAD_MAX, d1, 16'h0003, 16'h0000, 16'h0000);
        load(2, RELOAD_MAX, d1, 16'h0003, 16'h0000, 16'h0000);
        output_enable_reg = 6'h3F;
        reset_irq_enable = 1'b1;
        deadtime_tick = 1'b1;
        counter_run_bits = 3'h7;
        trig_chk = 1'b1;
        waitp(4);
        trig_chk = 1'b0;
        check(per + 1, irq_t - irq_prev);
        check(d0 + 1, width(0));
        check(d1 - 3, width(1));
        check(md(ps + 5), md(rise_t[1] - rise_t[0]));
        check(md(ss + 5), md(rise_t[2] - rise_t[0]));
        check(0, seen_s);
        $display("test 1 done");
        d0n = d0 + 16'(4 + $urandom % 8);
        d1n = d1 + 16'(2 + $urandom % 8);
        for (int i = 0; i < 3; i++)
        begin
            timer_cfg[i].shadow_on = 1'b1;
            timer_cfg[i].update_on_reset = 1'b1;
            timer_cfg[i].update_disable = 1'b1;
        end
        load(0, per, d0n, ps, d0n / 2, ss);
        load(1, RELOAD_MAX, d1n, 16'h0003, 16'h0000, 16'h0000);
        load(2, RELOAD_MAX, d1n, 16'h0003, 16'h0000, 16'h0000);
        waitp(3);
        check(d0 + 1, width(0));
        check(d1 - 3, width(1));
        check(d1 - 3, width(2));
        timer_cfg[0].update_disable = 1'b0;
        timer_cfg[1].update_disable = 1'b0;
        timer_cfg[2].update_disable = 1'b0;
        waitp(3);
        check(d0n + 1, width(0));
        check(d1n - 3, width(1));
        check(d1n - 3, width(2));
        $display("test 2 done");
        repeat_irq_select = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            repeat_count = 8'(k * (1 + $urandom % 3));
            waitp(3 * (repeat_count + 1));
            check((repeat_count + 1) * (per + 1), irq_t - irq_prev);
        end
        repeat_irq_select = 1'b0;
        $display("test 3 done");
        output_enable_reg = 6'h2A;
        waitp(1);
        seen_f = '0;
        waitp(2);
        check(0, seen_f);
        counter_run_bits = 3'h0;
        repeat (3) @(negedge clk);
        cnt = lead_count;
        repeat (20) @(negedge clk);
        check(cnt, lead_count);
        counter_run_bits = 3'h7;
        output_enable_reg = 6'h3F;
        $display("test 4 done");
        fv = 9'(2 + $urandom % 5);
        for (int i = 0; i < 3; i++)
            // Unequal dead-times show whether rise and fall were swapped.
            timer_cfg[i] = '{1'b1, 1'b1, 1'b1, 1'b0, 9'(fv + 4), fv};
        waitp(1);
        seen_s = '0;
        waitp(3);
        check(1, dt_gap >= fv && dt_gap <= fv + 3);
        check(3'h7, seen_s);
        check(0, n_shoot);
        check(1, n_conv > 0);
        output_enable_reg = 6'h15;
        waitp(1);
        seen_s = '0;
        waitp(2);
        check(0, seen_s);
        $display("test 5 done");
        results();
    end
endmodule

`default_nettype wire
